//--- bench/adc_serial_result_output_tb_top.sv
// Purpose: Testbench of the serial result output
// Assumes: CLK 100 ns, CE held high
// Notes: Internal and external shifting, refusal, lost update
`timescale 1ns/1ps
module adc_serial_result_output_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic src = 1'b0;
	logic [15:0] res = 16'h0000;
	wire rc, sel_n, xclk, chain, cst, busy_n, sco, oen, sdo;
	int err_total = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	adcsr_host i_host (.rc(rc), .sel_n(sel_n), .sclk(xclk), .chain(chain), .busy_n(busy_n),
		.sdo(sdo));
	adcsr_top i_dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .SHIFT_CLOCK_IN(xclk),
		.CLOCK_SOURCE_SELECT(src), .READ_CONVERT(rc), .SELECT_N(sel_n), .CHAIN_IN(chain),
		.CONV_RESULT(res), .CONV_START(cst), .BUSY_N(busy_n), .SHIFT_CLOCK_OUT(sco),
		.SHIFT_CLOCK_OE_N(oen), .SERIAL_OUT_LINE(sdo));
	task automatic summarize();
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic t_int(input logic [15:0] r, input logic [15:0] exp);
		logic [31:0] w;
		int n;
		int starts;
		logic p;
		w = '0;
		n = 0;
		starts = 0;
		p = 1'b0;
		res = r;
		fork
			begin
				i_host.convert(1'b1, 1'b0);
				#700;
				i_host.convert(1'b1, 1'b0);
			end
			repeat (70) begin
				@(posedge clk);
				#1;
				if (sco === 1'b1 && !p) begin
					w = {w[30:0], sdo};
					n++;
				end
				if (cst === 1'b1) starts++;
				p = sco;
			end
		join
		chk("bit count", 32'h0000_0010, 32'(n));
		chk("word", {16'h0000, exp}, w);
		chk("chain level", 32'h0000_0001, {31'h0, sdo});
		chk("starts", 32'h0000_0001, 32'(starts));
	endtask : t_int
	task automatic t_ext(input logic [15:0] r, input logic hold, input int n,
		input logic [31:0] exp);
		logic [31:0] got;
		int k;
		src = 1'b1;
		res = r;
		repeat (3) @(posedge clk);
		#1;
		i_host.convert(1'b0, hold);
		for (k = 0; k < 100 && busy_n !== 1'b1; k++) @(posedge clk);
		if (k == 100) begin
			err_total++;
			summarize();
		end
		i_host.read(n, 32'h5A5A_0F0F, got);
		chk("ext word", exp, got);
		chk("clock drive", 32'h0000_0001, {31'h0, oen});
	endtask : t_ext
	initial begin
		logic [31:0] junk;
		repeat (4) @(posedge clk);
		i_host.pulses(1, 32'h0000_0000, junk);
		repeat (8) @(posedge clk);
		#1;
		rstn = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_int(16'hA5C3, 16'h0000);
		t_int(16'h3C5A, 16'hA5C3);
		t_ext(16'hC3E1, 1'b0, 32, {16'hC3E1, 16'h5A5A});
		t_ext(16'h7E81, 1'b1, 16, 32'h0000_0F0F);
		summarize();
	end
endmodule : adc_serial_result_output_tb_top

//--- bench/adcsr_asserts.sv
// Purpose: Port checks of the serial result output
// Assumes: CLK domain only
// Notes: Bound to the top module
`timescale 1ns/1ps
module adcsr_asserts (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic CONV_START,
	input wire logic BUSY_N,
	input wire logic SHIFT_CLOCK_OUT,
	input wire logic SHIFT_CLOCK_OE_N,
	input wire logic SERIAL_OUT_LINE
);
	logic [5:0] busy_cnt_r;
	logic [4:0] pulse_cnt_r;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	always_ff @(posedge CLK) begin
		busy_cnt_r <= (!RSTN || BUSY_N) ? 6'h00 : busy_cnt_r + 6'h01;
	end
	always_ff @(posedge CLK) begin
		if (!RSTN || CONV_START) begin
			pulse_cnt_r <= 5'h00;
		end else if ($rose(SHIFT_CLOCK_OUT)) begin
			pulse_cnt_r <= pulse_cnt_r + 5'h01;
		end
	end
	sequence s_low3;
		!SHIFT_CLOCK_OUT [*3];
	endsequence
	sequence s_low2;
		!SHIFT_CLOCK_OUT ##1 !SHIFT_CLOCK_OUT;
	endsequence
	conv_pulse_a: assert property (CONV_START |=> !CONV_START && !BUSY_N)
		else $error("start pulse bad");
	no_retrig_a: assert property (CONV_START |-> $past(BUSY_N))
		else $error("start while busy");
	busy_len_a: assert property ($rose(BUSY_N) |-> busy_cnt_r == 6'h17)
		else $error("busy length bad");
	first_clk_a: assert property (CONV_START && !CLOCK_SOURCE_SELECT |-> s_low3 ##1 SHIFT_CLOCK_OUT)
		else $error("first clock late");
	pulse_shape_a: assert property ($rose(SHIFT_CLOCK_OUT) |=> s_low2)
		else $error("clock shape bad");
	hold_bit_a: assert property (SHIFT_CLOCK_OUT |-> $stable(SERIAL_OUT_LINE) ##1 $stable(SERIAL_OUT_LINE))
		else $error("bit moved");
	pulse_count_a: assert property (pulse_cnt_r <= 5'h10)
		else $error("extra pulses");
	oe_drive_a: assert property (SHIFT_CLOCK_OUT |-> !SHIFT_CLOCK_OE_N)
		else $error("clock undriven");
endmodule : adcsr_asserts
bind adcsr_top adcsr_asserts i_chk (.CLK(CLK), .RSTN(RSTN), .CONV_START(CONV_START),
	.CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .BUSY_N(BUSY_N), .SHIFT_CLOCK_OUT(SHIFT_CLOCK_OUT),
	.SHIFT_CLOCK_OE_N(SHIFT_CLOCK_OE_N), .SERIAL_OUT_LINE(SERIAL_OUT_LINE));

//--- bench/adcsr_host.sv
// Purpose: Host model: convert, select, chain and link clock
// Assumes: Link clock 48 ns, still between frames
// Notes: Samples the line at each falling edge
`timescale 1ns/1ps
module adcsr_host (
	output logic rc,
	output logic sel_n,
	output logic sclk,
	output logic chain,
	input wire logic busy_n,
	input wire logic sdo
);
	initial begin
		rc = 1'b1;
		sel_n = 1'b1;
		sclk = 1'b0;
		chain = 1'b0;
	end
	task automatic pulses(input int n, input logic [31:0] din, output logic [31:0] got);
		got = '0;
		for (int i = 0; i < n; i++) begin
			chain = din[31-i];
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
			// Line only moves on rising edges, so it is settled here
			got = {got[30:0], sdo};
		end
	endtask : pulses
	task automatic read(input int n, input logic [31:0] din, output logic [31:0] got);
		logic [31:0] spare;
		pulses(4, 32'h0000_0000, spare);
		sel_n = 1'b0;
		#24;
		pulses(n, din, got);
		sel_n = 1'b1;
	endtask : read
	task automatic convert(input logic c, input logic hold);
		chain = c;
		sclk = hold;
		#10;
		rc = 1'b0;
		sel_n = 1'b0;
		#400;
		rc = 1'b1;
		for (int i = 0; i < 40 && hold && busy_n !== 1'b1; i++) #100;
		sel_n = 1'b1;
		#10;
		sclk = 1'b0;
	endtask : convert
endmodule : adcsr_host

//--- verilog/adcsr_pkg.sv
// Purpose: Shared constants and types of the serial result output block
// Assumes: CLK runs at 10 MHz
// Notes: Cycle counts are derived from the printed times
package adcsr_pkg;
	localparam int ADCSR_WORD_W = 16;
	localparam int ADCSR_CLK_PERIOD_NS = 100;

	// Busy low per conversion, typical figure; the maximum is 2500 ns
	localparam int ADCSR_BUSY_LOW_NS = 2300;
	localparam int ADCSR_BUSY_LOW_MAX_NS = 2500;
	localparam int ADCSR_BUSY_LOW_CYC_I = ADCSR_BUSY_LOW_NS / ADCSR_CLK_PERIOD_NS;
	localparam logic [5:0] ADCSR_BUSY_LOW_CYC = 6'(ADCSR_BUSY_LOW_CYC_I);
	// The output register is loaded one cycle before busy rises
	localparam logic [5:0] ADCSR_UPDATE_CYC = 6'(ADCSR_BUSY_LOW_CYC_I - 2);
	localparam logic [5:0] ADCSR_RELEASE_CYC = 6'(ADCSR_BUSY_LOW_CYC_I - 1);

	// Start of the output-register update window, as printed
	localparam int ADCSR_UPDATE_OFFSET_US = 12;
	// Previous result readable after conversion start
	localparam int ADCSR_PREV_VALID_NS = 2200;

	// Delay from convert to the first internal shift clock, rounded up
	localparam int ADCSR_SCLK_DELAY_NS = 171;
	localparam int ADCSR_SCLK_DELAY_CYC_I =
		(ADCSR_SCLK_DELAY_NS + ADCSR_CLK_PERIOD_NS - 1) / ADCSR_CLK_PERIOD_NS;
	localparam logic [3:0] ADCSR_SCLK_DELAY_CYC = 4'(ADCSR_SCLK_DELAY_CYC_I);

	// Internal shift clock period bounds; half period never below one cycle
	localparam int ADCSR_SCLK_MIN_NS = 92;
	localparam int ADCSR_SCLK_MAX_NS = 98;
	localparam int ADCSR_SCLK_HALF_I = (ADCSR_SCLK_MAX_NS / 2) / ADCSR_CLK_PERIOD_NS;
	localparam int ADCSR_SCLK_HALF_CYC_I = (ADCSR_SCLK_HALF_I < 1) ? 1 : ADCSR_SCLK_HALF_I;
	localparam logic [3:0] ADCSR_SCLK_HALF_CYC = 4'(ADCSR_SCLK_HALF_CYC_I);
	localparam logic [3:0] ADCSR_SCLK_LAST_PH = 4'(2 * ADCSR_SCLK_HALF_CYC_I);

	localparam logic [3:0] ADCSR_LAST_BIT = 4'h0_00F;
	localparam logic [15:0] ADCSR_RESULT_RST = 16'h0000;

	// Pins crossing into the CLK domain
	localparam int ADCSR_PIN_W = 5;
	localparam int ADCSR_PIN_RC = 0;
	localparam int ADCSR_PIN_SEL_N = 1;
	localparam int ADCSR_PIN_SRC = 2;
	localparam int ADCSR_PIN_CHAIN = 3;
	localparam int ADCSR_PIN_XCLK = 4;

	typedef enum logic [1:0] {
		ADCSR_IDLE = 2'b00,
		ADCSR_WAIT = 2'b01,
		ADCSR_SHIFT = 2'b11
	} adcsr_state_t;
endpackage : adcsr_pkg

//--- verilog/adcsr_sync.sv
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Each bit is an independent level
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
module adcsr_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	adcsr_sync_if.snk s
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_r <= '0;
			sync_r <= '0;
		end else if (ce) begin
			meta_r <= s.raw;
			sync_r <= meta_r;
		end
	end

	assign s.synced = sync_r;
endmodule : adcsr_sync

//--- verilog/adcsr_sync_if.sv
// Purpose: Carries a group of levels into a synchroniser and back
// Assumes: Raw side may be asynchronous to the synchroniser clock
// Notes: One instance per destination clock domain
`timescale 1ns/1ps
interface adcsr_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport snk (input raw, output synced);
endinterface : adcsr_sync_if

//--- verilog/adcsr_top.sv
// Purpose: Serial result output of a sampling converter, internal or external shift clock
// Assumes: CONV_RESULT is on CLK; SHIFT_CLOCK_IN comes from the host; pins are host driven
// Notes: READ_CONVERT and SELECT_N are used directly on the link clock under host setup
`timescale 1ns/1ps
module adcsr_top
	import adcsr_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic SHIFT_CLOCK_IN,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic READ_CONVERT,
	input wire logic SELECT_N,
	input wire logic CHAIN_IN,
	input wire logic [15:0] CONV_RESULT,
	output logic CONV_START,
	output logic BUSY_N,
	output logic SHIFT_CLOCK_OUT,
	output logic SHIFT_CLOCK_OE_N,
	output logic SERIAL_OUT_LINE
);
	// CLK domain pin synchroniser
	adcsr_sync_if #(.W(ADCSR_PIN_W)) pin_if ();
	adcsr_sync #(.W(ADCSR_PIN_W)) u_pin_sync (
		.clk(CLK),
		.rstn(RSTN),
		.ce(CE),
		.s(pin_if.snk)
	);
	assign pin_if.raw = {SHIFT_CLOCK_IN, CHAIN_IN, CLOCK_SOURCE_SELECT, SELECT_N, READ_CONVERT};

	logic rc_q;
	logic sel_n_q;
	logic ext_mode_q;
	logic chain_q;
	logic xclk_q;
	assign rc_q = pin_if.synced[ADCSR_PIN_RC];
	assign sel_n_q = pin_if.synced[ADCSR_PIN_SEL_N];
	assign ext_mode_q = pin_if.synced[ADCSR_PIN_SRC];
	assign chain_q = pin_if.synced[ADCSR_PIN_CHAIN];
	assign xclk_q = pin_if.synced[ADCSR_PIN_XCLK];

	// Conversion control
	logic start_cond;
	logic start_cond_d_r;
	logic start_pulse;
	logic busy_n_r;
	logic [5:0] conv_cnt_r;
	logic conv_start_r;
	logic [15:0] result_r;
	logic upd_tgl_r;
	logic update_now;
	logic update_lost;

	assign start_cond = ~rc_q & ~sel_n_q;
	// Only a fresh convert command while not converting is taken
	assign start_pulse = start_cond & ~start_cond_d_r & busy_n_r;
	assign update_now = ~busy_n_r & (conv_cnt_r == ADCSR_UPDATE_CYC);
	// Host reading in external mode with clock high at the update suppresses the load
	assign update_lost = ext_mode_q & ~sel_n_q & rc_q & xclk_q;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			// Synced pins read low just after reset; treat that as already seen
			start_cond_d_r <= 1'b1;
		end else if (CE) begin
			start_cond_d_r <= start_cond;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			busy_n_r <= 1'b1;
			conv_cnt_r <= '0;
			conv_start_r <= 1'b0;
		end else if (CE) begin
			conv_start_r <= start_pulse;
			if (start_pulse) begin
				busy_n_r <= 1'b0;
				conv_cnt_r <= '0;
			end else if (!busy_n_r) begin
				conv_cnt_r <= conv_cnt_r + 6'h0_001;
				// Busy low for a fixed count within the maximum
				if (conv_cnt_r == ADCSR_RELEASE_CYC) begin
					busy_n_r <= 1'b1;
				end
			end
		end
	end

	// Output register, loaded a cycle before busy rises
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			result_r <= ADCSR_RESULT_RST;
			upd_tgl_r <= 1'b0;
		end else if (CE) begin
			if (update_now && !update_lost) begin
				result_r <= CONV_RESULT;
				upd_tgl_r <= ~upd_tgl_r;
			end
		end
	end

	// Internal shift clock engine
	adcsr_state_t state_r;
	logic [3:0] dly_r;
	logic [3:0] ph_r;
	logic [3:0] bit_r;
	logic [15:0] ish_r;
	logic itag_r;
	logic iout_r;
	logic sclk_r;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_r <= ADCSR_IDLE;
			dly_r <= '0;
			ph_r <= '0;
			bit_r <= '0;
			ish_r <= ADCSR_RESULT_RST;
			itag_r <= 1'b0;
			iout_r <= 1'b0;
			sclk_r <= 1'b0;
		end else if (CE) begin
			case (state_r)
				ADCSR_IDLE: begin
					sclk_r <= 1'b0;
					if (start_pulse && !ext_mode_q) begin
						state_r <= ADCSR_WAIT;
						dly_r <= '0;
						// Copy of result N-1, independent of the coming update
						ish_r <= result_r;
						itag_r <= chain_q;
					end
				end
				ADCSR_WAIT: begin
					dly_r <= dly_r + 4'h0_001;
					if (dly_r == ADCSR_SCLK_DELAY_CYC - 4'h0_001) begin
						state_r <= ADCSR_SHIFT;
						ph_r <= '0;
						bit_r <= '0;
						iout_r <= ish_r[15];
					end
				end
				ADCSR_SHIFT: begin
					if (ph_r == 4'h0_000) begin
						sclk_r <= 1'b1;
					end
					if (ph_r == ADCSR_SCLK_HALF_CYC) begin
						sclk_r <= 1'b0;
					end
					if (ph_r == ADCSR_SCLK_LAST_PH) begin
						// Data moves only after the falling edge
						ph_r <= '0;
						ish_r <= {ish_r[14:0], 1'b0};
						bit_r <= bit_r + 4'h0_001;
						if (bit_r == ADCSR_LAST_BIT) begin
							state_r <= ADCSR_IDLE;
							iout_r <= itag_r;
						end else begin
							iout_r <= ish_r[14];
						end
					end else begin
						ph_r <= ph_r + 4'h0_001;
					end
				end
				default: begin
					state_r <= ADCSR_IDLE;
				end
			endcase
		end
	end

	// Link clock domain: external shift register
	adcsr_sync_if #(.W(1)) tgl_if ();
	adcsr_sync #(.W(1)) u_tgl_sync (
		.clk(SHIFT_CLOCK_IN),
		.rstn(RSTN),
		.ce(CE),
		.s(tgl_if.snk)
	);
	assign tgl_if.raw = upd_tgl_r;

	logic tgl_seen_r;
	logic reload;
	logic [15:0] xsh_r;
	logic xout_r;
	logic xmode_r;

	assign reload = tgl_if.synced[0] ^ tgl_seen_r;

	always_ff @(posedge SHIFT_CLOCK_IN) begin
		if (!RSTN) begin
			tgl_seen_r <= 1'b0;
			xsh_r <= ADCSR_RESULT_RST;
			xout_r <= 1'b0;
		end else if (CE) begin
			tgl_seen_r <= tgl_if.synced[0];
			if (reload) begin
				// result_r is stable for a whole conversion once the toggle arrives
				xsh_r <= result_r;
			end else if (!SELECT_N && READ_CONVERT) begin
				xout_r <= xsh_r[15];
				xsh_r <= {xsh_r[14:0], CHAIN_IN};
			end
		end
	end

	// Output pins
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			xmode_r <= 1'b0;
			SHIFT_CLOCK_OE_N <= 1'b1;
		end else if (CE) begin
			xmode_r <= ext_mode_q;
			SHIFT_CLOCK_OE_N <= ext_mode_q;
		end
	end

	assign CONV_START = conv_start_r;
	assign BUSY_N = busy_n_r;
	assign SHIFT_CLOCK_OUT = sclk_r;
	// Selects between two flip-flops of different domains
	assign SERIAL_OUT_LINE = xmode_r ? xout_r : iout_r;
endmodule : adcsr_top
